// file: hdl/core_exec.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module core_exec
    import exec_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // instruction issue from sequencer
    input  wire logic        issue_valid_i,
    input  wire issue_t      issue_i,
    output logic             issue_ready_o,
    output logic             done_o,
    output logic             illegal_o,
    // stack memory read port, data one cycle after the strobe
    output logic             stack_rd_o,
    output logic      [7:0]  stack_addr_o,
    input  wire logic [7:0]  stack_data_i
);

    typedef enum logic {S_IDLE, S_RUN} state_t;

    function automatic decode_t decode(input logic [7:0] op);
        decode_t d;
        d = '{legal: 1'b1, is_reti: 1'b0, is_ror: 1'b0, dst: DST_A,
              src: SRC_IMM, cycles: CYC_ILLEGAL};
        case (op)
            OP_RETI: begin
                d.is_reti = 1'b1;
                d.cycles = CYC_RETI;
            end
            OP_SUBB_B_A: begin
                d.src = SRC_B;
                d.cycles = CYC_SUBB_B_A;
            end
            OP_SUBB_R_A: begin
                d.src = SRC_R;
                d.cycles = CYC_SUBB_R_A;
            end
            OP_SUBB_R_B: begin
                d.src = SRC_R;
                d.dst = DST_B;
                d.cycles = CYC_SUBB_R_B;
            end
            OP_SUBB_R_R: begin
                d.src = SRC_R;
                d.dst = DST_R;
                d.cycles = CYC_SUBB_R_R;
            end
            OP_SUBB_I_A: d.cycles = CYC_SUBB_I_A;
            OP_SUBB_I_B: begin
                d.dst = DST_B;
                d.cycles = CYC_SUBB_I_B;
            end
            OP_SUBB_I_R: begin
                d.dst = DST_R;
                d.cycles = CYC_SUBB_I_R;
            end
            OP_ROR_A: begin
                d.is_ror = 1'b1;
                d.cycles = CYC_ROR_AB;
            end
            OP_ROR_B: begin
                d.is_ror = 1'b1;
                d.dst = DST_B;
                d.cycles = CYC_ROR_AB;
            end
            OP_ROR_R: begin
                d.is_ror = 1'b1;
                d.dst = DST_R;
                d.cycles = CYC_ROR_R;
            end
            default: d.legal = 1'b0;
        endcase
        return d;
    endfunction

    // returns {status, result}
    function automatic logic [15:0] sub_borrow(input logic [7:0] dst,
                                               input logic [7:0] src,
                                               input logic [7:0] st);
        logic [8:0] diff;
        logic [7:0] s;
        diff = {1'b0, dst} - {1'b0, src} - 9'h001
             + {8'h00, st[ST_C]};
        s = st;
        s[ST_C] = ~diff[8];
        s[ST_N] = diff[MSB];
        s[ST_Z] = (diff[7:0] == 8'h00);
        s[ST_V] = (s[ST_C] ^ s[ST_N]) & (src[MSB] ^ dst[MSB]);
        return {s, diff[7:0]};
    endfunction

    function automatic logic [15:0] rot_right(input logic [7:0] dst,
                                              input logic [7:0] st);
        logic [7:0] r;
        logic [7:0] s;
        r = {dst[0], dst[7:1]};
        s = st;
        s[ST_C] = dst[0];
        s[ST_N] = r[MSB];
        s[ST_Z] = (r == 8'h00);
        s[ST_V] = 1'b0;
        return {s, r};
    endfunction

    state_t      state_ff, nxt_state;
    logic [3:0]  cnt_ff, nxt_cnt;
    issue_t      ins_ff, nxt_ins;
    decode_t     dec_ff, nxt_dec;
    logic [7:0]  src_ff, nxt_src;
    logic [7:0]  dst_ff, nxt_dst;
    logic [7:0]  acc_a_ff, nxt_acc_a;
    logic [7:0]  acc_b_ff, nxt_acc_b;
    logic [7:0]  status_ff, nxt_status;
    logic [15:0] pc_ff, nxt_pc;
    logic [7:0]  sp_ff, nxt_sp;
    logic        ill_ff, nxt_ill;
    logic [31:0] prdata_ff, nxt_prdata;

    logic [7:0]  mem_addr;
    logic        mem_wr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic [7:0]  dst_val;
    logic [15:0] res;
    logic        apb_xfer;
    logic        apb_hit;
    logic        busy;

    regfile_mem u_mem (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .addr_i  (mem_addr),
        .wr_i    (mem_wr),
        .wdata_i (mem_wdata),
        .rdata_o (mem_rdata)
    );

    assign busy          = (state_ff == S_RUN);
    assign issue_ready_o = ~busy & ce_i;
    assign apb_xfer      = psel_i & penable_i & ce_i;
    // ce low stretches the access instead of losing it
    assign pready_o      = ce_i;
    assign prdata_o      = prdata_ff;

    always_comb begin
        case (paddr_i)
            OFS_ACC_A, OFS_ACC_B, OFS_STATUS,
            OFS_PC, OFS_SP, OFS_EXEC: apb_hit = 1'b1;
            default:                  apb_hit = 1'b0;
        endcase
    end
    // writes during an instruction would race the datapath, so refuse them
    assign pslverr_o = psel_i & penable_i & (~apb_hit | (pwrite_i & busy));

    always_comb begin
        case (dec_ff.dst)
            DST_A:   dst_val = acc_a_ff;
            DST_B:   dst_val = acc_b_ff;
            default: dst_val = dst_ff;
        endcase
        res = dec_ff.is_ror ? rot_right(dst_val, status_ff)
                            : sub_borrow(dst_val, src_ff, status_ff);
    end

    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_ins    = ins_ff;
        nxt_dec    = dec_ff;
        nxt_src    = src_ff;
        nxt_dst    = dst_ff;
        nxt_acc_a  = acc_a_ff;
        nxt_acc_b  = acc_b_ff;
        nxt_status = status_ff;
        nxt_pc     = pc_ff;
        nxt_sp     = sp_ff;
        nxt_ill    = ill_ff;
        nxt_prdata = prdata_ff;
        mem_addr   = ins_ff.source_register;
        mem_wr     = 1'b0;
        mem_wdata  = res[7:0];
        stack_rd_o = 1'b0;
        done_o     = 1'b0;
        illegal_o  = 1'b0;

        if (apb_xfer & ~pwrite_i) begin
            case (paddr_i)
                OFS_ACC_A:  nxt_prdata = {24'h000000, acc_a_ff};
                OFS_ACC_B:  nxt_prdata = {24'h000000, acc_b_ff};
                OFS_STATUS: nxt_prdata = {24'h000000, status_ff};
                OFS_PC:     nxt_prdata = {16'h0000, pc_ff};
                OFS_SP:     nxt_prdata = {24'h000000, sp_ff};
                OFS_EXEC:   nxt_prdata = {30'h0, ill_ff, busy};
                default:    nxt_prdata = 32'h00000000;
            endcase
        end
        if (apb_xfer & pwrite_i & ~busy) begin
            case (paddr_i)
                OFS_ACC_A:  nxt_acc_a = pwdata_i[7:0];
                OFS_ACC_B:  nxt_acc_b = pwdata_i[7:0];
                OFS_STATUS: nxt_status = pwdata_i[7:0];
                OFS_PC:     nxt_pc = pwdata_i[15:0];
                OFS_SP:     nxt_sp = pwdata_i[7:0];
                default:    nxt_ill = ill_ff;
            endcase
        end

        case (state_ff)
            S_IDLE: begin
                if (issue_valid_i) begin
                    nxt_state = S_RUN;
                    nxt_cnt   = RST_CNT;
                    nxt_ins   = issue_i;
                    nxt_dec   = decode(issue_i.opcode);
                    nxt_src   = issue_i.immediate_byte;
                end
            end
            S_RUN: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (dec_ff.is_reti) begin
                    case (cnt_ff)
                        STEP_RD_SRC, STEP_RD_HI, STEP_RD_ST: stack_rd_o = 1'b1;
                        STEP_POP_LO: begin
                            nxt_pc[7:0] = stack_data_i;
                            nxt_sp = sp_ff - 8'h01;
                        end
                        STEP_POP_HI: begin
                            nxt_pc[15:8] = stack_data_i;
                            nxt_sp = sp_ff - 8'h01;
                        end
                        STEP_POP_ST: begin
                            nxt_status = stack_data_i;
                            nxt_sp = sp_ff - 8'h01;
                        end
                        default: stack_rd_o = 1'b0;
                    endcase
                end else if (dec_ff.legal) begin
                    case (cnt_ff)
                        STEP_RD_SRC: mem_addr = ins_ff.source_register;
                        STEP_RD_DST: begin
                            mem_addr = ins_ff.dest_register;
                            if (dec_ff.src == SRC_R) begin
                                nxt_src = mem_rdata;
                            end else if (dec_ff.src == SRC_B) begin
                                nxt_src = acc_b_ff;
                            end
                        end
                        STEP_GET_DST: begin
                            mem_addr = ins_ff.dest_register;
                            nxt_dst  = mem_rdata;
                        end
                        STEP_EXEC: begin
                            mem_addr   = ins_ff.dest_register;
                            nxt_status = res[15:8];
                            case (dec_ff.dst)
                                DST_A:   nxt_acc_a = res[7:0];
                                DST_B:   nxt_acc_b = res[7:0];
                                default: mem_wr = 1'b1;
                            endcase
                        end
                        default: mem_wr = 1'b0;
                    endcase
                end
                if (cnt_ff == dec_ff.cycles - 4'h1) begin
                    nxt_state = S_IDLE;
                    done_o    = 1'b1;
                    illegal_o = ~dec_ff.legal;
                    nxt_ill   = ~dec_ff.legal;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    always_comb begin
        stack_addr_o = sp_ff;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff  <= S_IDLE;
            cnt_ff    <= RST_CNT;
            ins_ff    <= '0;
            dec_ff    <= '0;
            src_ff    <= RST_BYTE;
            dst_ff    <= RST_BYTE;
            acc_a_ff  <= RST_BYTE;
            acc_b_ff  <= RST_BYTE;
            status_ff <= RST_BYTE;
            pc_ff     <= RST_PC;
            sp_ff     <= RST_SP;
            ill_ff    <= 1'b0;
            prdata_ff <= '0;
        end else if (ce_i) begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            ins_ff    <= nxt_ins;
            dec_ff    <= nxt_dec;
            src_ff    <= nxt_src;
            dst_ff    <= nxt_dst;
            acc_a_ff  <= nxt_acc_a;
            acc_b_ff  <= nxt_acc_b;
            status_ff <= nxt_status;
            pc_ff     <= nxt_pc;
            sp_ff     <= nxt_sp;
            ill_ff    <= nxt_ill;
            prdata_ff <= nxt_prdata;
        end
    end

endmodule

// file: hdl/exec_pkg.sv
package exec_pkg;

    // opcodes
    localparam logic [7:0] OP_RETI      = 8'hFA;
    localparam logic [7:0] OP_SUBB_B_A  = 8'h6B;
    localparam logic [7:0] OP_SUBB_R_A  = 8'h1B;
    localparam logic [7:0] OP_SUBB_R_B  = 8'h3B;
    localparam logic [7:0] OP_SUBB_R_R  = 8'h4B;
    localparam logic [7:0] OP_SUBB_I_A  = 8'h2B;
    localparam logic [7:0] OP_SUBB_I_B  = 8'h5B;
    localparam logic [7:0] OP_SUBB_I_R  = 8'h7B;
    localparam logic [7:0] OP_ROR_A     = 8'hBC;
    localparam logic [7:0] OP_ROR_B     = 8'hCC;
    localparam logic [7:0] OP_ROR_R     = 8'hDC;

    // cycle counts per opcode
    localparam logic [3:0] CYC_RETI     = 4'hC;
    localparam logic [3:0] CYC_SUBB_B_A = 4'h8;
    localparam logic [3:0] CYC_SUBB_R_A = 4'h7;
    localparam logic [3:0] CYC_SUBB_R_B = 4'h7;
    localparam logic [3:0] CYC_SUBB_R_R = 4'h9;
    localparam logic [3:0] CYC_SUBB_I_A = 4'h6;
    localparam logic [3:0] CYC_SUBB_I_B = 4'h6;
    localparam logic [3:0] CYC_SUBB_I_R = 4'h8;
    localparam logic [3:0] CYC_ROR_AB   = 4'h8;
    localparam logic [3:0] CYC_ROR_R    = 4'h6;
    localparam logic [3:0] CYC_ILLEGAL  = 4'h1;

    // step numbers inside an instruction
    localparam logic [3:0] STEP_RD_SRC  = 4'h0;
    localparam logic [3:0] STEP_RD_DST  = 4'h1;
    localparam logic [3:0] STEP_GET_DST = 4'h2;
    localparam logic [3:0] STEP_EXEC    = 4'h3;
    localparam logic [3:0] STEP_POP_LO  = 4'h1;
    localparam logic [3:0] STEP_RD_HI   = 4'h2;
    localparam logic [3:0] STEP_POP_HI  = 4'h3;
    localparam logic [3:0] STEP_RD_ST   = 4'h4;
    localparam logic [3:0] STEP_POP_ST  = 4'h5;

    // status bit positions
    localparam int ST_C = 7;
    localparam int ST_N = 6;
    localparam int ST_Z = 5;
    localparam int ST_V = 4;
    localparam int MSB  = 7;

    // apb byte offsets
    localparam logic [7:0] OFS_ACC_A  = 8'h00;
    localparam logic [7:0] OFS_ACC_B  = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PC     = 8'h0C;
    localparam logic [7:0] OFS_SP     = 8'h10;
    localparam logic [7:0] OFS_EXEC   = 8'h14;

    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_PC   = 16'h0000;
    localparam logic [7:0]  RST_SP   = 8'h01;
    localparam logic [3:0]  RST_CNT  = 4'h0;

    typedef enum logic [1:0] {DST_A, DST_B, DST_R} dst_kind_t;
    typedef enum logic [1:0] {SRC_B, SRC_R, SRC_IMM} src_kind_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] source_register;
        logic [7:0] dest_register;
        logic [7:0] immediate_byte;
    } issue_t;

    typedef struct packed {
        logic       legal;
        logic       is_reti;
        logic       is_ror;
        dst_kind_t  dst;
        src_kind_t  src;
        logic [3:0] cycles;
    } decode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// file: hdl/regfile_mem.sv
`timescale 1ns/1ps
module regfile_mem
    import exec_pkg::*;
(
    // clock
    input  wire logic       clk_i,
    input  wire logic       ce_i,
    // access port
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);
    // no reset on the array: contents undefined until software writes them
    logic [7:0] mem [256];
    logic [7:0] rdata_ff;

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (wr_i) begin
                mem[addr_i] <= wdata_i;
            end
            rdata_ff <= mem[addr_i];
        end
    end

    assign rdata_o = rdata_ff;
endmodule

// file: test/core_exec_assertions.sv
`timescale 1ns/1ps
module core_exec_assertions
    import exec_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       ce_i,
    // apb
    input  wire logic       psel_i,
    input  wire logic       penable_i,
    input  wire logic [7:0] paddr_i,
    input  wire logic       pready_o,
    input  wire logic       pslverr_o,
    // issue and stack
    input  wire logic       issue_valid_i,
    input  wire issue_t     issue_i,
    input  wire logic       issue_ready_o,
    input  wire logic       done_o,
    input  wire logic       illegal_o,
    input  wire logic       stack_rd_o,
    input  wire logic [7:0] stack_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic take;
    logic reti;
    logic ba_go;
    logic imm_go;
    assign take   = issue_valid_i && issue_ready_o;
    assign reti   = take && issue_i.opcode == OP_RETI;
    assign ba_go  = take && issue_i.opcode == OP_SUBB_B_A;
    assign imm_go = take && issue_i.opcode == OP_SUBB_I_A;
    sequence ba_wait;
        !done_o [*7] ##1 done_o;
    endsequence
    sequence pop_seq;
        stack_rd_o ##2 stack_rd_o ##2 stack_rd_o;
    endsequence
    sequence sp_step;
        stack_rd_o ##2
        (stack_rd_o && stack_addr_o == $past(stack_addr_o, 2) - 8'h01);
    endsequence
    a_pready_ce: assert property (pready_o == ce_i)
        else $error("pready differs from clock enable");
    a_reti_len: assert property (reti |=> ##11 done_o)
        else $error("return from interrupt not done in 12 cycles");
    a_reti_pops: assert property (reti |=> pop_seq)
        else $error("return from interrupt pop strobes wrong");
    a_reti_sp: assert property (reti |=> sp_step)
        else $error("stack pointer not decremented between pops");
    a_subb_ba_len: assert property (ba_go |=> ba_wait)
        else $error("register subtract length wrong");
    a_subb_imm_len: assert property (imm_go |=> ##5 done_o)
        else $error("immediate subtract length wrong");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_illegal_done: assert property (illegal_o |-> done_o)
        else $error("illegal without done");
    a_busy_refuse: assert property (take |=> !issue_ready_o)
        else $error("ready while busy");
    a_unmapped_err: assert property (psel_i && penable_i
        && paddr_i > OFS_EXEC |-> pslverr_o)
        else $error("unmapped access without error");
endmodule

bind core_exec core_exec_assertions u_chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .issue_valid_i(issue_valid_i),
    .issue_i(issue_i), .issue_ready_o(issue_ready_o), .done_o(done_o),
    .illegal_o(illegal_o), .stack_rd_o(stack_rd_o),
    .stack_addr_o(stack_addr_o)
);

// file: test/stack_mem_model.sv
`timescale 1ns/1ps
module stack_mem_model (
    // clock
    input  wire logic       clk_i,
    // read port
    input  wire logic       rd_i,
    input  wire logic [7:0] addr_i,
    output logic      [7:0] data_o
);
    logic [7:0] mem [256];
    logic       vld_ff  = 1'b0;
    logic [7:0] q_ff    = 8'h00;
    logic [7:0] last_ff = 8'h00;
    always @(posedge clk_i) begin
        vld_ff  <= rd_i;
        last_ff <= data_o;
        if (rd_i) begin
            q_ff <= mem[addr_i];
        end
    end
    // valid only the cycle after a strobe; junk otherwise catches late use
    assign data_o = vld_ff ? q_ff : ~last_ff;
endmodule

// file: test/interrupt_return_and_borrow_subtract_tb.sv
`timescale 1ns/1ps
module interrupt_return_and_borrow_subtract_tb
    import exec_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        ce_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic        issue_valid_i = 1'b0;
    issue_t      issue_i = '0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        issue_ready_o;
    logic        done_o;
    logic        illegal_o;
    logic        stack_rd_o;
    logic [7:0]  stack_addr_o;
    logic [7:0]  stack_data_i;
    logic [31:0] q;
    logic        e;
    int          num_errors = 0;
    int          compares = 0;
    int          cyc = 0;
    always #5 clk_i = ~clk_i;
    core_exec u_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .issue_valid_i(issue_valid_i),
        .issue_i(issue_i), .issue_ready_o(issue_ready_o),
        .done_o(done_o), .illegal_o(illegal_o), .stack_rd_o(stack_rd_o),
        .stack_addr_o(stack_addr_o), .stack_data_i(stack_data_i)
    );
    stack_mem_model u_mem (
        .clk_i(clk_i), .rd_i(stack_rd_o), .addr_i(stack_addr_o),
        .data_o(stack_data_i)
    );
    task automatic summarize();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // prdata is registered at the access edge, so read it at the falling edge after it
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(negedge clk_i);
        while (pready_o !== 1'b1) @(negedge clk_i);
        e = pslverr_o;
        @(posedge clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(negedge clk_i);
        q = prdata_o;
    endtask
    task automatic chk_reg(input string nm, input logic [7:0] a,
                           input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, q, exp);
    endtask
    task automatic start_op(input logic [7:0] op, s, d, m);
        @(posedge clk_i);
        issue_valid_i <= 1'b1;
        issue_i <= {op, s, d, m};
        @(negedge clk_i);
        while (issue_ready_o !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
        issue_valid_i <= 1'b0;
    endtask
    task automatic run(input logic [7:0] op, m, input logic [3:0] n,
                       input logic ill);
        int k;
        start_op(op, 8'h03, 8'h04, m);
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (done_o !== 1'b1 && k < 40);
        check("cycles", k, n);
        check("illegal", illegal_o, ill);
    endtask
    task automatic t_reset();
        chk_reg("acc_a", OFS_ACC_A, 32'h0);
        chk_reg("status", OFS_STATUS, 32'h0);
        chk_reg("sp", OFS_SP, 32'h01);
        chk_reg("unmapped", 8'h18, 32'h0);
        check("slverr", e, 1'b1);
    endtask
    task automatic t_rotate();
        apb(1'b1, OFS_ACC_B, 32'h93);
        apb(1'b1, OFS_STATUS, 32'h0);
        run(OP_ROR_B, 8'h00, CYC_ROR_AB, 1'b0);
        chk_reg("ror_b", OFS_ACC_B, 32'hC9);
        chk_reg("ror_st", OFS_STATUS, 32'hC0);
        apb(1'b1, OFS_ACC_A, 32'h92);
        apb(1'b1, OFS_STATUS, 32'h80);
        run(OP_ROR_A, 8'h00, CYC_ROR_AB, 1'b0);
        chk_reg("ror_a", OFS_ACC_A, 32'h49);
        chk_reg("ror_st0", OFS_STATUS, 32'h0);
    endtask
    task automatic t_subb();
        logic [31:0] tab [7] = '{32'h6B502001, 32'h6B000101,
            32'h2B050000, 32'h2B050001, 32'h5B800101, 32'h5B000000,
            32'h2B101001};
        logic [8:0] t;
        logic [7:0] op, dst, src, r;
        logic       c, cn;
        logic [7:0] ra;
        logic [31:0] st_exp;
        for (int i = 0; i < 7; i++) begin
            {op, dst, src} = tab[i][31:8];
            c = tab[i][0];
            ra = (op == OP_SUBB_I_B) ? OFS_ACC_B : OFS_ACC_A;
            t = {1'b0, dst} - {1'b0, src} - 9'h001 + {8'h00, c};
            r = t[7:0];
            cn = ~t[8];
            st_exp = {24'h0, cn, r[7], r == 8'h00,
                      (cn ^ r[7]) & (src[7] ^ dst[7]), 4'h0};
            apb(1'b1, OFS_STATUS, {24'h0, c, 7'h0});
            apb(1'b1, ra, {24'h0, dst});
            apb(1'b1, OFS_ACC_B, (op == OP_SUBB_B_A) ? {24'h0, src}
                                                     : {24'h0, dst});
            run(op, src, (op == OP_SUBB_B_A) ? CYC_SUBB_B_A : CYC_SUBB_I_A,
                1'b0);
            chk_reg("subb_res", ra, {24'h0, r});
            chk_reg("subb_st", OFS_STATUS, st_exp);
        end
    endtask
    task automatic t_reti();
        // stacked status differs from what the previous scenario leaves
        u_mem.mem[8'h30] = 8'h34;
        u_mem.mem[8'h2F] = 8'h12;
        u_mem.mem[8'h2E] = 8'h50;
        apb(1'b1, OFS_SP, 32'h30);
        run(OP_RETI, 8'h00, CYC_RETI, 1'b0);
        chk_reg("pc", OFS_PC, 32'h1234);
        chk_reg("st", OFS_STATUS, 32'h50);
        chk_reg("sp", OFS_SP, 32'h2D);
    endtask
    task automatic t_forms();
        run(OP_SUBB_R_A, 8'h00, CYC_SUBB_R_A, 1'b0);
        run(OP_SUBB_R_B, 8'h00, CYC_SUBB_R_B, 1'b0);
        run(OP_SUBB_R_R, 8'h00, CYC_SUBB_R_R, 1'b0);
        run(OP_SUBB_I_R, 8'h00, CYC_SUBB_I_R, 1'b0);
        run(OP_ROR_R, 8'h00, CYC_ROR_R, 1'b0);
        run(8'h00, 8'h00, CYC_ILLEGAL, 1'b1);
        chk_reg("exec", OFS_EXEC, 32'h2);
    endtask
    task automatic t_busy_ce();
        start_op(OP_SUBB_I_A, 8'h00, 8'h00, 8'h00);
        apb(1'b1, OFS_ACC_A, 32'h55);
        check("busy_wr", e, 1'b1);
        repeat (8) @(posedge clk_i);
        ce_i <= 1'b0;
        @(negedge clk_i);
        check("ce_ready", pready_o, 1'b0);
        check("ce_issue", issue_ready_o, 1'b0);
        @(posedge clk_i);
        ce_i <= 1'b1;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_rotate();
        t_subb();
        t_reti();
        t_forms();
        t_busy_ce();
        summarize();
    end
endmodule
